/* hdc_pkg.sv */
// package: register map, field layout, reset values and timing for the headset detect control registers
package hdc_pkg;

  // register offsets
  localparam logic [7:0] OFS_DAC_FILT   = 8'h0c;
  localparam logic [7:0] OFS_DET_A      = 8'h0d;
  localparam logic [7:0] OFS_DET_B      = 8'h0e;
  localparam logic [7:0] OFS_ADC_GAIN   = 8'h0f;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h11;

  // dac_filter_enables fields
  localparam int BIT_L_EFFECTS = 3;
  localparam int BIT_L_DEEMPH  = 2;
  localparam int BIT_R_EFFECTS = 1;
  localparam int BIT_R_DEEMPH  = 0;

  // headset_detect_ctrl_a fields
  localparam int BIT_DET_EN    = 7;
  localparam int POS_HS_TYPE   = 5;
  localparam int POS_JACK_DEB  = 2;
  localparam int POS_BTN_DEB   = 0;

  // headset_detect_ctrl_b fields
  localparam int BIT_AC_COUPLED = 7;
  localparam int BIT_FULLY_DIFF = 6;
  localparam int BIT_BTN_FLAG   = 5;
  localparam int BIT_HS_FLAG    = 4;
  localparam int BIT_PSEUDO_DIFF = 3;

  // left_adc_gain_ctrl fields
  localparam int BIT_PGS_MUTE = 7;

  // interrupt status / mask fields
  localparam int IRQ_W       = 2;
  localparam int BIT_IRQ_BTN = 0;
  localparam int BIT_IRQ_JACK = 1;

  // reset values
  localparam logic [3:0]       DAC_FILT_RST = 4'h0;
  localparam logic [7:0]       DET_A_RST    = 8'h00;
  localparam logic [7:0]       DET_B_RST    = 8'h00;
  localparam logic             PGS_MUTE_RST = 1'b1;
  localparam logic [IRQ_W-1:0] IRQ_RST      = 2'h0;

  // debounce timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int TICK_PERIOD_MS = 1;
  localparam int NS_PER_MS      = 1000000;
  localparam int CLKS_PER_MS    = (TICK_PERIOD_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int DEB_SAMPLES    = 8;
  localparam logic [2:0] JACK_DEB_MAX = 3'h5;

  typedef struct packed {
    logic left_effects_en;
    logic left_deemph_en;
    logic right_effects_en;
    logic right_deemph_en;
    logic hp_ac_coupled;
    logic stereo_fully_diff;
    logic stereo_pseudo_diff;
    logic left_programmable_gain_stage_mute;
  } hdc_ctrl_t;

  typedef struct packed {
    logic cellular;
    logic stereo;
  } hdc_hs_sense_t;

endpackage

/* hdc_regs.sv */
// headset detect control registers: filter enables, jack and button debounce, driver configuration, mute
`timescale 1ns/1ps
`default_nettype none

// debouncer: output follows the input once it held one level for DEB_SAMPLES sample ticks in a row
module hdc_debounce #(
  parameter int W       = 1,
  parameter int SAMPLES = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic         clear,
  input  wire logic         bypass,
  input  wire logic         sample_tick,
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] stable
);

  localparam int CW = $clog2(SAMPLES + 1);
  localparam logic [CW-1:0] LAST = CW'(SAMPLES - 1);
  logic [CW-1:0] match_cnt_r;
  logic [W-1:0]  cand_r;
  logic [W-1:0]  stable_r;

  if (SAMPLES < 2) $error("hdc_debounce needs at least two samples");
  always_ff @(posedge sys_clk) begin
    if (!resetn || clear) begin
      match_cnt_r <= '0;
      cand_r      <= '0;
    end else if (sample_tick) begin
      // a sample that differs from the candidate restarts the count
      if (raw != cand_r) begin
        cand_r      <= raw;
        match_cnt_r <= '0;
      end else if (match_cnt_r != LAST) begin
        match_cnt_r <= match_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || clear) begin
      stable_r <= '0;
    end else if (bypass) begin
      stable_r <= raw;
    end else if (sample_tick && raw == cand_r && match_cnt_r == LAST - 1'b1) begin
      stable_r <= raw; // R16
    end
  end

  assign stable = stable_r;

endmodule

// Overview of operation
// (R1) Left and right dac effects filter enables sit at bits 3 and 1 of dac_filter_enables, 1 inserts, reset 0.
// (R2) Left and right de-emphasis enables sit at bits 2 and 0 of dac_filter_enables, 1 inserts, reset 0.
// (R3) Bit 7 of headset_detect_ctrl_a enables headset detection, reset 0.
// (R4) Bits 6-5 of headset_detect_ctrl_a read the detected type: none, stereo, cellular or both.
// (R5) Jack debounce code 0 gives 16 ms on a 2 ms sample tick and each code up to 5 doubles both.
// (R6) Software never programs jack debounce codes 6 or 7.
// (R7) Button debounce code 0 is none, codes 1 to 3 give 8, 16, 32 ms on 1, 2, 4 ms ticks.
// (R8) Bit 7 of headset_detect_ctrl_b selects ac-coupled (1) or capless (0) outputs, reset 0.
// (R9) Bit 6 of headset_detect_ctrl_b flags a stereo fully-differential output, reset 0.
// (R10) Bit 3 of headset_detect_ctrl_b flags a stereo pseudo-differential output, reset 0.
// (R11) Software never sets bits 6 and 3 of headset_detect_ctrl_b together.
// (R12) The button flag at bit 5 sets on a debounced press and is cleared by reading the register.
// (R13) The headset flag at bit 4 reads 1 while a headset is detected, reset 0.
// (R14) Bits 2-0 of headset_detect_ctrl_b are reserved, read 0 and are written with zeros.
// (R15) Bit 7 of left_adc_gain_ctrl mutes the left programmable gain stage and resets to 1.
// (R16) A debounced status changes only after the input held one level for every tick of the period; disabling detection zeroes it at once.
module hdc_regs
  import hdc_pkg::*;
#(
  parameter int CLKS_PER_MS_P = CLKS_PER_MS
) (
  input  wire logic          sys_clk,
  input  wire logic          resetn,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr_stb,
  input  wire logic          reg_rd_stb,
  output logic      [7:0]    reg_rdata,
  input  wire hdc_pkg::hdc_hs_sense_t hs_sense,
  input  wire logic          button_sense,
  output hdc_pkg::hdc_ctrl_t ctrl,
  output logic               irq
);
  import hdc_pkg::*;

  localparam int MSW = $clog2(CLKS_PER_MS_P);
  if (CLKS_PER_MS_P < 2) $error("hdc_regs: CLKS_PER_MS_P must be at least 2");

  // bus decode
  logic wr_dac, wr_det_a, wr_det_b, wr_gain, wr_status, wr_mask, rd_det_b;
  assign wr_dac    = reg_wr_stb && reg_addr == OFS_DAC_FILT;
  assign wr_det_a  = reg_wr_stb && reg_addr == OFS_DET_A;
  assign wr_det_b  = reg_wr_stb && reg_addr == OFS_DET_B;
  assign wr_gain   = reg_wr_stb && reg_addr == OFS_ADC_GAIN;
  assign wr_status = reg_wr_stb && reg_addr == OFS_IRQ_STATUS;
  assign wr_mask   = reg_wr_stb && reg_addr == OFS_IRQ_MASK;
  assign rd_det_b  = reg_rd_stb && reg_addr == OFS_DET_B;

  // software controlled state
  logic [3:0] dac_filt_r;
  logic       det_en_r;
  logic [2:0] jack_deb_r;
  logic [1:0] btn_deb_r;
  logic       ac_coupled_r;
  logic       fully_diff_r;
  logic       pseudo_diff_r;
  logic       pgs_mute_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      dac_filt_r <= DAC_FILT_RST; // R1 R2
    end else if (wr_dac) begin
      dac_filt_r <= reg_wdata[3:0]; // R1 R2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      det_en_r   <= DET_A_RST[BIT_DET_EN]; // R3
      jack_deb_r <= DET_A_RST[POS_JACK_DEB +: 3];
      btn_deb_r  <= DET_A_RST[POS_BTN_DEB +: 2];
    end else if (wr_det_a) begin
      det_en_r   <= reg_wdata[BIT_DET_EN]; // R3
      jack_deb_r <= reg_wdata[POS_JACK_DEB +: 3]; // R5
      btn_deb_r  <= reg_wdata[POS_BTN_DEB +: 2]; // R7
    end
  end

  // reserved bits 2-0 are not stored, so they always read back zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ac_coupled_r  <= DET_B_RST[BIT_AC_COUPLED]; // R8
      fully_diff_r  <= DET_B_RST[BIT_FULLY_DIFF]; // R9
      pseudo_diff_r <= DET_B_RST[BIT_PSEUDO_DIFF]; // R10
    end else if (wr_det_b) begin
      ac_coupled_r  <= reg_wdata[BIT_AC_COUPLED]; // R8
      fully_diff_r  <= reg_wdata[BIT_FULLY_DIFF]; // R9
      pseudo_diff_r <= reg_wdata[BIT_PSEUDO_DIFF]; // R10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pgs_mute_r <= PGS_MUTE_RST; // R15
    end else if (wr_gain) begin
      pgs_mute_r <= reg_wdata[BIT_PGS_MUTE]; // R15
    end
  end

  // both configuration bits are driven as written; keeping them exclusive is left to software
  always_comb begin
    ctrl.left_effects_en                   = dac_filt_r[BIT_L_EFFECTS]; // R1
    ctrl.left_deemph_en                    = dac_filt_r[BIT_L_DEEMPH]; // R2
    ctrl.right_effects_en                  = dac_filt_r[BIT_R_EFFECTS]; // R1
    ctrl.right_deemph_en                   = dac_filt_r[BIT_R_DEEMPH]; // R2
    ctrl.hp_ac_coupled                     = ac_coupled_r; // R8
    ctrl.stereo_fully_diff                 = fully_diff_r; // R9
    ctrl.stereo_pseudo_diff                = pseudo_diff_r; // R10
    ctrl.left_programmable_gain_stage_mute = pgs_mute_r; // R15
  end

  // pin synchronisers
  logic [2:0] sense_meta_r;
  logic [2:0] sense_sync_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sense_meta_r <= 3'h0;
      sense_sync_r <= 3'h0;
    end else begin
      sense_meta_r <= {button_sense, hs_sense};
      sense_sync_r <= sense_meta_r;
    end
  end

  // millisecond tick
  logic [MSW-1:0] clk_cnt_r;
  logic           ms_tick_r;
  logic [6:0]     ms_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      clk_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else if (clk_cnt_r == MSW'(CLKS_PER_MS_P - 1)) begin
      clk_cnt_r <= '0;
      ms_tick_r <= 1'b1;
    end else begin
      clk_cnt_r <= clk_cnt_r + 1'b1;
      ms_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ms_cnt_r <= 7'h00;
    end else if (ms_tick_r) begin
      ms_cnt_r <= ms_cnt_r + 1'b1;
    end
  end

  // sample ticks: jack every 2<<code ms (64 ms for codes 5 to 7), button every 1<<(code-1) ms, both eight samples per period
  logic [6:0] jack_mask;
  logic [6:0] btn_mask;
  logic       jack_tick;
  logic       btn_tick;
  always_comb begin
    case (jack_deb_r)
      3'h0:    jack_mask = 7'h01; // R5
      3'h1:    jack_mask = 7'h03;
      3'h2:    jack_mask = 7'h07;
      3'h3:    jack_mask = 7'h0f;
      3'h4:    jack_mask = 7'h1f;
      3'h5:    jack_mask = 7'h3f;
      default: jack_mask = 7'h3f; // R6
    endcase
  end

  always_comb begin
    case (btn_deb_r)
      2'h1:    btn_mask = 7'h00; // R7
      2'h2:    btn_mask = 7'h01;
      2'h3:    btn_mask = 7'h03;
      default: btn_mask = 7'h00;
    endcase
  end

  assign jack_tick = ms_tick_r && (ms_cnt_r & jack_mask) == 7'h00;
  assign btn_tick  = ms_tick_r && (ms_cnt_r & btn_mask) == 7'h00;

  // debounced jack and button
  logic [1:0] hs_type;
  logic       btn_stable;
  logic       btn_stable_d_r;
  hdc_debounce #(
    .W       (2),
    .SAMPLES (DEB_SAMPLES)
  ) u_jack_deb (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .clear       (!det_en_r),
    .bypass      (1'b0),
    .sample_tick (jack_tick),
    .raw         (sense_sync_r[1:0]),
    .stable      (hs_type)
  );

  hdc_debounce #(
    .W       (1),
    .SAMPLES (DEB_SAMPLES)
  ) u_btn_deb (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .clear       (!det_en_r),
    .bypass      (btn_deb_r == 2'h0),
    .sample_tick (btn_tick),
    .raw         (sense_sync_r[2]),
    .stable      (btn_stable)
  );

  logic hs_present;
  logic hs_present_d_r;
  logic btn_press;
  logic jack_change;
  assign hs_present = |hs_type; // R13

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      btn_stable_d_r <= 1'b0;
      hs_present_d_r <= 1'b0;
    end else begin
      btn_stable_d_r <= btn_stable;
      hs_present_d_r <= hs_present;
    end
  end

  // a press only counts while detection runs and a headset is in
  assign btn_press   = btn_stable && !btn_stable_d_r && hs_present;
  assign jack_change = hs_present != hs_present_d_r;

  // sticky button flag
  logic btn_flag_r;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      btn_flag_r <= 1'b0;
    end else if (btn_press) begin
      btn_flag_r <= 1'b1; // R12
    end else if (rd_det_b) begin
      btn_flag_r <= 1'b0; // R12
    end
  end

  // interrupt status and mask
  logic [IRQ_W-1:0] irq_status_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_set;
  always_comb begin
    irq_set               = '0;
    irq_set[BIT_IRQ_BTN]  = btn_press;
    irq_set[BIT_IRQ_JACK] = jack_change;
  end

  // a new event in the clearing cycle survives the write of one
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_status_r <= IRQ_RST;
    end else begin
      irq_status_r <= (irq_status_r & ~(wr_status ? reg_wdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_mask_r <= IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_r <= reg_wdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // read path
  logic [7:0] rd_mux;
  logic [7:0] rdata_r;
  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      OFS_DAC_FILT:   rd_mux[3:0] = dac_filt_r;
      OFS_DET_A: begin
        rd_mux[BIT_DET_EN]          = det_en_r;
        rd_mux[POS_HS_TYPE +: 2]    = hs_type; // R4
        rd_mux[POS_JACK_DEB +: 3]   = jack_deb_r;
        rd_mux[POS_BTN_DEB +: 2]    = btn_deb_r;
      end
      OFS_DET_B: begin
        rd_mux[BIT_AC_COUPLED]  = ac_coupled_r;
        rd_mux[BIT_FULLY_DIFF]  = fully_diff_r;
        rd_mux[BIT_BTN_FLAG]    = btn_flag_r; // R12
        rd_mux[BIT_HS_FLAG]     = hs_present; // R13
        rd_mux[BIT_PSEUDO_DIFF] = pseudo_diff_r;
        rd_mux[2:0]             = 3'h0; // R14
      end
      OFS_ADC_GAIN:   rd_mux[BIT_PGS_MUTE] = pgs_mute_r;
      OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_r;
      OFS_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_r;
      default:        rd_mux = 8'h00;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_stb) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata = rdata_r;

endmodule

`default_nettype wire

/* hdc_regs_assertions.sv */
// checker: port-level properties of the headset detect control registers
`timescale 1ns/1ps
`default_nettype none
module hdc_regs_checker
  import hdc_pkg::*;
#(
  parameter int CLKS_PER_MS_P = 4
) (
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr_stb,
  input wire logic                   reg_rd_stb,
  input wire logic [7:0]             reg_rdata,
  input wire hdc_pkg::hdc_hs_sense_t hs_sense,
  input wire logic                   button_sense,
  input wire hdc_pkg::hdc_ctrl_t     ctrl,
  input wire logic                   irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  a_eff_write: assert property (
    reg_wr_stb && reg_addr == OFS_DAC_FILT |=> ctrl.left_effects_en == $past(reg_wdata[BIT_L_EFFECTS])
      && ctrl.right_effects_en == $past(reg_wdata[BIT_R_EFFECTS])) else $error("effects enables wrong");
  a_deemph_write: assert property (
    reg_wr_stb && reg_addr == OFS_DAC_FILT |=> ctrl.left_deemph_en == $past(reg_wdata[BIT_L_DEEMPH])
      && ctrl.right_deemph_en == $past(reg_wdata[BIT_R_DEEMPH])) else $error("de-emphasis enables wrong");
  a_coupling_write: assert property (
    reg_wr_stb && reg_addr == OFS_DET_B |=> ctrl.hp_ac_coupled == $past(reg_wdata[BIT_AC_COUPLED]))
    else $error("coupling bit wrong");
  a_config_write: assert property (
    reg_wr_stb && reg_addr == OFS_DET_B |=> ctrl.stereo_fully_diff == $past(reg_wdata[BIT_FULLY_DIFF])
      && ctrl.stereo_pseudo_diff == $past(reg_wdata[BIT_PSEUDO_DIFF])) else $error("driver config wrong");
  a_mute_write: assert property (
    reg_wr_stb && reg_addr == OFS_ADC_GAIN |=> ctrl.left_programmable_gain_stage_mute == $past(reg_wdata[7]))
    else $error("mute bit wrong");
  a_reset_values: assert property (
    $rose(resetn) |-> ctrl == 8'h01) else $error("ctrl reset value wrong");
  // ctrl is pure register state: any change without a write is a leak
  a_ctrl_holds: assert property (
    $past(resetn) && !$past(reg_wr_stb) |-> $stable(ctrl)) else $error("ctrl changed without write");
  a_rdata_idle: assert property (
    !$past(reg_rd_stb) |-> reg_rdata == 8'h00) else $error("read data outside read cycle");
  a_reserved_zero: assert property (
    $past(reg_rd_stb) && $past(reg_addr) == OFS_DET_B |-> reg_rdata[2:0] == 3'h0)
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property (
    $past(reg_rd_stb) && ($past(reg_addr) < OFS_DAC_FILT || $past(reg_addr) > OFS_IRQ_MASK)
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_irq_masked: assert property (
    reg_wr_stb && reg_addr == OFS_IRQ_MASK && reg_wdata[1:0] == 2'h0 |=> !irq)
    else $error("irq high with mask cleared");
endmodule
bind hdc_regs hdc_regs_checker #(.CLKS_PER_MS_P(CLKS_PER_MS_P)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
  .reg_rdata(reg_rdata), .hs_sense(hs_sense), .button_sense(button_sense), .ctrl(ctrl), .irq(irq));
`default_nettype wire

/* hdc_sense_model.sv */
// jack and button sensing model: plug levels and a bouncing button contact
`timescale 1ns/1ps
`default_nettype none
module hdc_sense_model
  import hdc_pkg::*;
#(
  parameter int BOUNCE = 3
) (
  input  wire logic                   sys_clk,
  input  wire hdc_pkg::hdc_hs_sense_t plug_cmd,
  input  wire logic                   press_cmd,
  output var  hdc_pkg::hdc_hs_sense_t hs_sense,
  output var  logic                   button_sense
);
  logic [3:0] bnc_r  = 4'h0;
  logic       last_r = 1'b0;
  initial hs_sense = '0;
  initial button_sense = 1'b0;
  // a real contact chatters on every change, so the debouncer never sees a clean step
  always @(posedge sys_clk) begin
    last_r <= press_cmd;
    hs_sense <= plug_cmd;
    if (press_cmd != last_r) bnc_r <= 4'(BOUNCE);
    else if (bnc_r != 4'h0) bnc_r <= bnc_r - 4'h1;
    button_sense <= (bnc_r != 4'h0) ? ~button_sense : press_cmd;
  end
endmodule
`default_nettype wire

/* headset_detect_ctrl_regs_tb_top.sv */
// testbench for the headset detect control registers
`timescale 1ns/1ps
`default_nettype none
module headset_detect_ctrl_regs_tb_top;
  import hdc_pkg::*;
  localparam int CPM = 4;
  logic          sys_clk = 1'b0, resetn = 1'b0, reg_wr_stb = 1'b0, reg_rd_stb = 1'b0, press_cmd = 1'b0;
  logic [7:0]    reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d, v;
  logic          button_sense, irq;
  hdc_hs_sense_t plug_cmd = '0, hs_sense;
  hdc_ctrl_t     ctrl;
  logic [7:0]    cfgs [4] = '{8'h80, 8'h40, 8'h08, 8'h00};
  int            failures = 0, cmp_count = 0, n, tk;

  hdc_sense_model #(.BOUNCE(3)) u_model (.sys_clk(sys_clk), .plug_cmd(plug_cmd), .press_cmd(press_cmd),
    .hs_sense(hs_sense), .button_sense(button_sense));
  hdc_regs #(.CLKS_PER_MS_P(CPM)) uut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata),
    .hs_sense(hs_sense), .button_sense(button_sense), .ctrl(ctrl), .irq(irq));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t %s: got %h exp %h", $time, m, g, e);
    end
  endtask
  task timeout;
    if (n > 600) begin
      failures++;
      $display("MISMATCH %0t wait ran out", $time);
      test_done();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= x;
    reg_wr_stb <= 1'b1;
    @(posedge sys_clk);
    reg_wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd_stb <= 1'b1;
    @(posedge sys_clk);
    reg_rd_stb <= 1'b0;
    #1 x = reg_rdata;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
    rd(a, d);
    chk(d, e, m);
  endtask
  // polling costs two cycles a read, hence the slack in the upper bound
  task wait_type(input logic [1:0] t, input int lo, input int hi);
    n = 0;
    do begin
      rd(OFS_DET_A, d);
      n += 2;
      timeout();
    end while (d[6:5] !== t);
    chk({7'h0, n >= lo && n <= hi}, 8'h01, "jack debounce time");
  endtask
  task wait_irq(input int lo, input int hi);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge sys_clk);
      #1 n++;
      timeout();
    end
    chk({7'h0, n >= lo && n <= hi}, 8'h01, "button debounce time");
  endtask

  task test_reset;
    chk(ctrl, 8'h01, "ctrl reset");
    rdchk(OFS_DAC_FILT, 8'h00, "filter reset");
    rdchk(OFS_DET_A, DET_A_RST, "det a reset");
    rdchk(OFS_DET_B, DET_B_RST, "det b reset");
    rdchk(OFS_ADC_GAIN, 8'h80, "gain reset");
    rdchk(OFS_IRQ_MASK, 8'h00, "mask reset");
    rdchk(OFS_IRQ_STATUS, 8'h00, "status reset");
    chk({7'h0, irq}, 8'h00, "irq reset");
    rdchk(8'h20, 8'h00, "unmapped read");
    $display("test_reset done");
  endtask
  task test_rw;
    for (int i = 0; i < 16; i++) begin
      wr(OFS_DAC_FILT, 8'hf0 | 8'(i));
      chk({4'h0, ctrl[7:4]}, 8'(i), "filter ctrl");
      rdchk(OFS_DAC_FILT, 8'(i), "filter read");
    end
    for (int i = 0; i < 4; i++) begin
      wr(OFS_DET_B, cfgs[i]);
      chk({5'h0, ctrl[3:1]}, {5'h0, cfgs[i][7], cfgs[i][6], cfgs[i][3]}, "driver ctrl");
      rdchk(OFS_DET_B, cfgs[i], "driver read");
    end
    for (int j = 0; j < 6; j++) begin
      v = {3'h0, 3'(j), 2'(j)};
      wr(OFS_DET_A, v | 8'h60);
      rdchk(OFS_DET_A, v, "debounce codes");
    end
    wr(OFS_ADC_GAIN, 8'h7f);
    chk({7'h0, ctrl[0]}, 8'h00, "unmute");
    rdchk(OFS_ADC_GAIN, 8'h00, "gain read");
    wr(OFS_ADC_GAIN, 8'h80);
    chk({7'h0, ctrl[0]}, 8'h01, "mute");
    wr(8'h20, 8'hff);
    rdchk(8'h20, 8'h00, "unmapped write");
    $display("test_rw done");
  endtask
  task test_detect;
    wr(OFS_DET_A, 8'h81);
    @(posedge sys_clk);
    plug_cmd <= hdc_hs_sense_t'(2'h1);
    repeat (3) @(posedge sys_clk);
    plug_cmd <= '0;
    repeat (20 * CPM) @(posedge sys_clk);
    rdchk(OFS_DET_A, 8'h81, "glitch rejected");
    for (int t = 1; t < 4; t++) begin
      wr(OFS_DET_A, {3'h4, 2'h0, t == 2, 2'h1});
      tk = (2 * CPM) << (t == 2);
      @(posedge sys_clk);
      plug_cmd <= hdc_hs_sense_t'(2'(t));
      wait_type(2'(t), 7 * tk, 8 * tk + 12);
      rdchk(OFS_DET_B, 8'h10, "headset flag");
    end
    $display("test_detect done");
  endtask
  task test_button;
    wr(OFS_IRQ_STATUS, 8'h03);
    wr(OFS_IRQ_MASK, 8'h01);
    chk({7'h0, irq}, 8'h00, "irq idle");
    @(posedge sys_clk);
    press_cmd <= 1'b1;
    wait_irq(7 * CPM, 8 * CPM + 12);
    rdchk(OFS_DET_B, 8'h30, "button flag set");
    rdchk(OFS_DET_B, 8'h10, "flag cleared by read");
    chk({7'h0, irq}, 8'h01, "irq sticky");
    wr(OFS_IRQ_STATUS, 8'h01);
    chk({7'h0, irq}, 8'h00, "irq cleared");
    @(posedge sys_clk);
    press_cmd <= 1'b0;
    repeat (20 * CPM) @(posedge sys_clk);
    wr(OFS_DET_A, 8'h80);
    wr(OFS_IRQ_MASK, 8'h00);
    @(posedge sys_clk);
    press_cmd <= 1'b1;
    repeat (12) @(posedge sys_clk);
    #1 chk({7'h0, irq}, 8'h00, "irq masked");
    rdchk(OFS_IRQ_STATUS, 8'h01, "undebounced press");
    wr(OFS_IRQ_MASK, 8'h01);
    chk({7'h0, irq}, 8'h01, "irq unmasked");
    @(posedge sys_clk);
    press_cmd <= 1'b0;
    // release chatter passes straight through with no debounce, so clear after it settles
    repeat (12) @(posedge sys_clk);
    wr(OFS_IRQ_STATUS, 8'h03);
    chk({7'h0, irq}, 8'h00, "irq cleared again");
    rd(OFS_DET_B, d);
    $display("test_button done");
  endtask
  task test_disable;
    @(posedge sys_clk);
    plug_cmd <= '0;
    wait_type(2'h0, 14 * CPM, 16 * CPM + 12);
    rdchk(OFS_DET_B, 8'h00, "headset flag clear");
    // unplugging raises the jack event, but its mask bit is still off
    rdchk(OFS_IRQ_STATUS, 8'h02, "jack change event");
    chk({7'h0, irq}, 8'h00, "jack event masked");
    @(posedge sys_clk);
    plug_cmd <= hdc_hs_sense_t'(2'h1);
    wait_type(2'h1, 14 * CPM, 16 * CPM + 12);
    wr(OFS_DET_A, 8'h00);
    repeat (4) @(posedge sys_clk);
    rdchk(OFS_DET_A, 8'h00, "type cleared when off");
    rdchk(OFS_DET_B, 8'h00, "flag cleared when off");
    $display("test_disable done");
  endtask

  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    #1;
    test_reset();
    test_rw();
    test_detect();
    test_button();
    test_disable();
    test_done();
  end
endmodule
`default_nettype wire
